// ### rtl/aics_pkg.sv
// Package: register map, field positions and reset values for the analog input config/status block
package aics_pkg;
    // Word addresses on the module side; byte address on AXI is four times the word
    localparam int unsigned          PT_WORD_LAST    = 11;   // Point data words 0..11
    localparam int unsigned          QUAL_WORD       = 12;   // Per-point quality word
    localparam int unsigned          CFG_WORD        = 13;   // Shared config/status word
    localparam logic [7:0]           CFG_BYTE_ADDR   = 8'h34;
    localparam logic [7:0]           QUAL_BYTE_ADDR  = 8'h30;
    localparam logic [7:0]           PT_BYTE_LAST    = 8'h2c;
    // Field positions
    localparam int unsigned          B_CONFIGURED    = 0;
    localparam int unsigned          B_ERROR         = 1;
    localparam int unsigned          B_CHECKSUM      = 7;
    localparam int unsigned          B_LINE50        = 8;
    localparam int unsigned          B_TRACK         = 9;
    localparam int unsigned          B_TRACK_ACT     = 10;
    localparam int unsigned          B_PROG_EN       = 11;
    localparam int unsigned          B_REF_PULSE     = 12;
    localparam int unsigned          B_MEM_ERR       = 13;
    localparam int unsigned          B_TEMP_FAIL     = 14;
    localparam int unsigned          B_POINT_FAULT   = 15;
    // Reset values of the writable bits
    localparam logic                 RST_CONFIGURED  = 1'b0;
    localparam logic                 RST_FORCE_ERR   = 1'b0;
    localparam logic                 RST_LINE50      = 1'b0;
    localparam logic                 RST_TRACK_REQ   = 1'b0;
    // Reference pulse check: window in ns, pulse at 625 kHz is 1600 ns apart
    localparam int unsigned          CLK_PERIOD_NS   = 8;
    localparam int unsigned          REF_WINDOW_NS   = 16000;
    localparam int unsigned          REF_WINDOW_CYC  = REF_WINDOW_NS / CLK_PERIOD_NS;
    // AXI responses
    localparam logic [1:0]           RESP_OKAY       = 2'h0;
    localparam logic [1:0]           RESP_SLVERR     = 2'h2;
    localparam logic [1:0]           RESP_DECERR     = 2'h3;
    // Init check states
    typedef enum logic [1:0] {
        INIT_WAIT  = 2'b00,
        INIT_DONE  = 2'b01,
        INIT_FAIL  = 2'b10
    } aics_init_type;
endpackage : aics_pkg

// ### rtl/aics_regs.sv
// Config/status word of a twelve-point analog input module, AXI4-Lite slave
// What this block does
// - Word 13 writes config, reads status.
// - Bit 0 configures; reads back configured state.
// - Unconfigured: point words 0-11 answer attention.
// - Write bit 1 forces error, lights indicator.
// - Read bit 1 internal-or-forced; indicator equals it.
// - Error set: point reads return attention.
// - Status bits 2-6 read zero.
// - Checksum fail: bit 7, error, fault, halt.
// - Bit 8 selects 80 or 83.3 ms timebase.
// - Bit 9 requests tracking; reads tracking in use.
// - Bit 10 shows tracking signal active.
// - Bit 11 mirrors program enable; gates programming.
// - Missing reference pulse at init sets bit 12.
// - Bit 13 reports memory/bus check failure.
// - Bit 14 temp sensor fail, always if uncalibrated.
// - Bit 15 ORs point quality, bits 1,7,12,13.
// - Temperature fault kept out of bit 15.
// - Quality word carries data only for point faults.
`timescale 1ns/1ps
module aics_regs #(
    parameter int unsigned REF_WINDOW = aics_pkg::REF_WINDOW_CYC
) (
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    input  wire logic [15:0] POINT_DATA,
    input  wire logic [15:0] POINT_QUALITY,
    input  wire logic        CHECKSUM_FAIL,
    input  wire logic        MEMORY_CHECK_FAIL,
    input  wire logic        TEMP_SENSOR_FAIL,
    input  wire logic        INTERNAL_FAULT,
    input  wire logic        REFERENCE_PULSE,
    input  wire logic        LINE_TRACK_PRESENT,
    input  wire logic        CALIB_MEMORY_PROGRAM_ENABLE,
    input  wire logic        PROGRAM_CMD,
    output logic [3:0]       POINT_INDEX,
    output logic             INTERNAL_ERROR_LED,
    output logic             POINT_PROCESS_EN,
    output logic             TIMEBASE_50HZ,
    output logic             TRACKING_IN_USE,
    output logic             PROGRAM_ACCEPT
);
    // ======================================================================
    // State
    // ======================================================================
    logic                  configured_reg, configured_next;
    logic                  force_err_reg, force_err_next;
    logic                  line50_reg, line50_next;
    logic                  track_req_reg, track_req_next;
    logic                  aw_held_reg, aw_held_next;
    logic                  w_held_reg, w_held_next;
    logic [7:0]            awaddr_reg, awaddr_next;
    logic [15:0]           wdata_reg, wdata_next;
    logic [1:0]            wstrb_reg, wstrb_next;
    logic                  bvalid_reg, bvalid_next;
    logic [1:0]            bresp_reg, bresp_next;
    logic                  rvalid_reg, rvalid_next;
    logic [31:0]           rdata_reg, rdata_next;
    logic [1:0]            rresp_reg, rresp_next;
    logic [15:0]           ref_cnt_reg, ref_cnt_next;
    logic                  ref_fail_reg, ref_fail_next;
    aics_pkg::aics_init_type init_reg, init_next;
    logic                  prog_acc_reg, prog_acc_next;
    logic [15:0]           status;
    logic                  module_error;
    logic                  do_write;
    logic                  point_attn;

    // ======================================================================
    // Status word assembly
    // ======================================================================
    // Error bit merges internal faults with the software force
    assign module_error = INTERNAL_FAULT | force_err_reg | CHECKSUM_FAIL
                        | ref_fail_reg | MEMORY_CHECK_FAIL;
    always_comb begin
        status                          = 16'h0000;
        status[aics_pkg::B_CONFIGURED]  = configured_reg;
        status[aics_pkg::B_ERROR]       = module_error;
        status[aics_pkg::B_CHECKSUM]    = CHECKSUM_FAIL;
        status[aics_pkg::B_LINE50]      = line50_reg;
        status[aics_pkg::B_TRACK]       = track_req_reg & LINE_TRACK_PRESENT;
        status[aics_pkg::B_TRACK_ACT]   = LINE_TRACK_PRESENT;
        status[aics_pkg::B_PROG_EN]     = CALIB_MEMORY_PROGRAM_ENABLE;
        status[aics_pkg::B_REF_PULSE]   = ref_fail_reg;
        status[aics_pkg::B_MEM_ERR]     = MEMORY_CHECK_FAIL;
        status[aics_pkg::B_TEMP_FAIL]   = TEMP_SENSOR_FAIL | CHECKSUM_FAIL;
        // Temperature fault deliberately absent from the summary
        status[aics_pkg::B_POINT_FAULT] = (|POINT_QUALITY) | module_error
                                        | CHECKSUM_FAIL | ref_fail_reg | MEMORY_CHECK_FAIL;
    end

    // Module-side outputs
    assign INTERNAL_ERROR_LED = status[aics_pkg::B_ERROR];
    assign POINT_PROCESS_EN   = ~CHECKSUM_FAIL & configured_reg;
    assign TIMEBASE_50HZ      = line50_reg;
    assign TRACKING_IN_USE    = status[aics_pkg::B_TRACK];
    assign PROGRAM_ACCEPT     = prog_acc_reg;
    assign point_attn         = ~configured_reg | module_error;
    assign POINT_INDEX        = S_AXI_ARADDR[5:2];

    // ======================================================================
    // Reference pulse check at initialization
    // ======================================================================
    // One look after reset; a late pulse cannot clear the failure
    always_comb begin
        init_next     = init_reg;
        ref_cnt_next  = ref_cnt_reg;
        ref_fail_next = ref_fail_reg;
        case (init_reg)
            aics_pkg::INIT_WAIT: begin
                if (REFERENCE_PULSE) begin
                    init_next = aics_pkg::INIT_DONE;
                end else if (ref_cnt_reg >= 16'(REF_WINDOW - 1)) begin
                    init_next     = aics_pkg::INIT_FAIL;
                    ref_fail_next = 1'b1;
                end else begin
                    ref_cnt_next = ref_cnt_reg + 16'h0001;
                end
            end
            aics_pkg::INIT_DONE: init_next = aics_pkg::INIT_DONE;
            aics_pkg::INIT_FAIL: init_next = aics_pkg::INIT_FAIL;
            default:             init_next = aics_pkg::INIT_WAIT;
        endcase
    end

    // Programming commands pass only with the enable strap high
    assign prog_acc_next = PROGRAM_CMD & CALIB_MEMORY_PROGRAM_ENABLE;

    // ======================================================================
    // AXI4-Lite write channel
    // ======================================================================
    assign S_AXI_AWREADY = ~aw_held_reg & ~bvalid_reg;
    assign S_AXI_WREADY  = ~w_held_reg & ~bvalid_reg;
    assign S_AXI_BVALID  = bvalid_reg;
    assign S_AXI_BRESP   = bresp_reg;
    assign do_write      = aw_held_reg & w_held_reg & ~bvalid_reg;

    // Address and data may arrive in either order; commit when both held
    always_comb begin
        aw_held_next    = aw_held_reg;
        w_held_next     = w_held_reg;
        awaddr_next     = awaddr_reg;
        wdata_next      = wdata_reg;
        wstrb_next      = wstrb_reg;
        bvalid_next     = bvalid_reg;
        bresp_next      = bresp_reg;
        configured_next = configured_reg;
        force_err_next  = force_err_reg;
        line50_next     = line50_reg;
        track_req_next  = track_req_reg;
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_held_next = 1'b1;
            awaddr_next  = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_held_next = 1'b1;
            wdata_next  = S_AXI_WDATA[15:0];
            wstrb_next  = S_AXI_WSTRB[1:0];
        end
        if (do_write) begin
            aw_held_next = 1'b0;
            w_held_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = aics_pkg::RESP_OKAY;
            if (awaddr_reg[7:2] == aics_pkg::CFG_BYTE_ADDR[7:2]) begin
                // Only bits 0,1,8,9 are stored; other lanes are dropped
                if (wstrb_reg[0]) begin
                    configured_next = wdata_reg[aics_pkg::B_CONFIGURED];
                    force_err_next  = wdata_reg[aics_pkg::B_ERROR];
                end
                if (wstrb_reg[1]) begin
                    line50_next    = wdata_reg[aics_pkg::B_LINE50];
                    track_req_next = wdata_reg[aics_pkg::B_TRACK];
                end
            end else if (awaddr_reg > aics_pkg::CFG_BYTE_ADDR) begin
                bresp_next = aics_pkg::RESP_DECERR;
            end else if (awaddr_reg <= aics_pkg::PT_BYTE_LAST && !configured_reg) begin
                // Point words refuse any access until configured; the
                // write is dropped either way, nothing there is writable
                bresp_next = aics_pkg::RESP_SLVERR;
            end
        end else if (bvalid_reg && S_AXI_BREADY) begin
            bvalid_next = 1'b0;
        end
    end

    // ======================================================================
    // AXI4-Lite read channel
    // ======================================================================
    assign S_AXI_ARREADY = ~rvalid_reg;
    assign S_AXI_RVALID  = rvalid_reg;
    assign S_AXI_RDATA   = rdata_reg;
    assign S_AXI_RRESP   = rresp_reg;

    // Point reads answer SLVERR as the attention status
    always_comb begin
        rvalid_next = rvalid_reg;
        rdata_next  = rdata_reg;
        rresp_next  = rresp_reg;
        if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            rvalid_next = 1'b1;
            rdata_next  = 32'h0000_0000;
            rresp_next  = aics_pkg::RESP_OKAY;
            if (S_AXI_ARADDR <= aics_pkg::PT_BYTE_LAST) begin
                if (point_attn) begin
                    rresp_next = aics_pkg::RESP_SLVERR;
                end else begin
                    rdata_next = {16'h0000, POINT_DATA};
                end
            end else if (S_AXI_ARADDR[7:2] == aics_pkg::QUAL_BYTE_ADDR[7:2]) begin
                // Suppressed while a checksum, reference, memory or forced error masks the cause
                if (!(CHECKSUM_FAIL | ref_fail_reg | MEMORY_CHECK_FAIL
                      | force_err_reg)) begin
                    rdata_next = {16'h0000, POINT_QUALITY};
                end
            end else if (S_AXI_ARADDR[7:2] == aics_pkg::CFG_BYTE_ADDR[7:2]) begin
                rdata_next = {16'h0000, status};
            end else begin
                rresp_next = aics_pkg::RESP_DECERR;
            end
        end else if (rvalid_reg && S_AXI_RREADY) begin
            rvalid_next = 1'b0;
        end
    end

    // ======================================================================
    // Registers
    // ======================================================================
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            configured_reg <= aics_pkg::RST_CONFIGURED;
            force_err_reg  <= aics_pkg::RST_FORCE_ERR;
            line50_reg     <= aics_pkg::RST_LINE50;
            track_req_reg  <= aics_pkg::RST_TRACK_REQ;
            aw_held_reg    <= 1'b0;
            w_held_reg     <= 1'b0;
            awaddr_reg     <= 8'h00;
            wdata_reg      <= 16'h0000;
            wstrb_reg      <= 2'h0;
            bvalid_reg     <= 1'b0;
            bresp_reg      <= 2'h0;
            rvalid_reg     <= 1'b0;
            rdata_reg      <= 32'h0000_0000;
            rresp_reg      <= 2'h0;
            ref_cnt_reg    <= 16'h0000;
            ref_fail_reg   <= 1'b0;
            init_reg       <= aics_pkg::INIT_WAIT;
            prog_acc_reg   <= 1'b0;
        end else begin
            configured_reg <= configured_next;
            force_err_reg  <= force_err_next;
            line50_reg     <= line50_next;
            track_req_reg  <= track_req_next;
            aw_held_reg    <= aw_held_next;
            w_held_reg     <= w_held_next;
            awaddr_reg     <= awaddr_next;
            wdata_reg      <= wdata_next;
            wstrb_reg      <= wstrb_next;
            bvalid_reg     <= bvalid_next;
            bresp_reg      <= bresp_next;
            rvalid_reg     <= rvalid_next;
            rdata_reg      <= rdata_next;
            rresp_reg      <= rresp_next;
            ref_cnt_reg    <= ref_cnt_next;
            ref_fail_reg   <= ref_fail_next;
            init_reg       <= init_next;
            prog_acc_reg   <= prog_acc_next;
        end
    end

    // ======================================================================
    // Checks
    // ======================================================================
    chk_led_follows_err: assert property (@(posedge CLK) disable iff (!RST_N)
        INTERNAL_ERROR_LED == (INTERNAL_FAULT | force_err_reg | CHECKSUM_FAIL
                               | ref_fail_reg | MEMORY_CHECK_FAIL))
        else $error("error indicator differs from error bit");
    chk_force_err_led: assert property (@(posedge CLK) disable iff (!RST_N)
        (do_write && awaddr_reg[7:2] == 6'h0d && wstrb_reg[0] && wdata_reg[1]) |=> INTERNAL_ERROR_LED)
        else $error("forced error did not light indicator");
    chk_config_bit_write: assert property (@(posedge CLK) disable iff (!RST_N)
        (do_write && awaddr_reg[7:2] == 6'h0d && wstrb_reg[0]) |=> configured_reg == $past(wdata_reg[0]))
        else $error("configure bit not taken");
    chk_unused_zero: assert property (@(posedge CLK) disable iff (!RST_N)
        (S_AXI_RVALID && S_AXI_RRESP == 2'h0 && $past(S_AXI_ARADDR) == 8'h34 && $rose(S_AXI_RVALID))
        |-> S_AXI_RDATA[6:2] == 5'h00)
        else $error("unused status bits not zero");
    chk_point_attn_resp: assert property (@(posedge CLK) disable iff (!RST_N)
        (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR <= 8'h2c && point_attn)
        |=> S_AXI_RVALID && S_AXI_RRESP == 2'h2 && S_AXI_RDATA == 32'h0)
        else $error("point read not answered with attention");
    chk_checksum_halts: assert property (@(posedge CLK) disable iff (!RST_N)
        CHECKSUM_FAIL |-> !POINT_PROCESS_EN && status[7] && status[15] && status[14])
        else $error("checksum fail not handled");
    chk_summary_fault: assert property (@(posedge CLK) disable iff (!RST_N)
        status[15] == ((|POINT_QUALITY) | status[1] | status[7] | status[12] | status[13]))
        else $error("summary fault mismatch");
    chk_temp_excluded: assert property (@(posedge CLK) disable iff (!RST_N)
        (TEMP_SENSOR_FAIL && !CHECKSUM_FAIL && status[1] == 1'b0 && POINT_QUALITY == 16'h0
         && !status[12] && !status[13]) |-> !status[15])
        else $error("temperature fault leaked into summary");
    chk_track_gated: assert property (@(posedge CLK) disable iff (!RST_N)
        TRACKING_IN_USE |-> track_req_reg && status[10])
        else $error("tracking in use without request and signal");
    chk_ref_timeout: assert property (@(posedge CLK) disable iff (!RST_N)
        (init_reg == aics_pkg::INIT_WAIT && !REFERENCE_PULSE && ref_cnt_reg == 16'(REF_WINDOW - 1))
        |=> ref_fail_reg && status[12])
        else $error("missing reference pulse not flagged");
    chk_prog_gate: assert property (@(posedge CLK) disable iff (!RST_N)
        PROGRAM_ACCEPT |-> $past(CALIB_MEMORY_PROGRAM_ENABLE))
        else $error("programming accepted while disabled");

    // Unconfigured point words answer attention on writes as well
    chk_point_write_attn: assert property (@(posedge CLK) disable iff (!RST_N)
        (do_write && awaddr_reg <= 8'h2c && !configured_reg) |=> S_AXI_BVALID && S_AXI_BRESP == 2'h2)
        else $error("unconfigured point write not refused");

    // Upper lane carries timebase and tracking request
    chk_timebase_write: assert property (@(posedge CLK) disable iff (!RST_N)
        (do_write && awaddr_reg[7:2] == 6'h0d && wstrb_reg[1]) |=> TIMEBASE_50HZ == $past(wdata_reg[8]))
        else $error("timebase select not taken");
    chk_track_req_write: assert property (@(posedge CLK) disable iff (!RST_N)
        (do_write && awaddr_reg[7:2] == 6'h0d && wstrb_reg[1]) |=> track_req_reg == $past(wdata_reg[9]))
        else $error("tracking request not taken");

    // Unstrobed lane 0 and other words leave the config alone
    chk_lane_masked: assert property (@(posedge CLK) disable iff (!RST_N)
        (do_write && !wstrb_reg[0]) |=> $stable(configured_reg) && $stable(force_err_reg))
        else $error("unstrobed config bits changed");
    chk_other_word_write: assert property (@(posedge CLK) disable iff (!RST_N)
        (do_write && awaddr_reg[7:2] != 6'h0d) |=> $stable(line50_reg) && $stable(track_req_reg)
        && $stable(configured_reg) && $stable(force_err_reg))
        else $error("write elsewhere changed config");

    // Quality word blanked while a checksum, reference, memory or forced error masks it
    chk_qual_masked: assert property (@(posedge CLK) disable iff (!RST_N)
        (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR[7:2] == 6'h0c
         && (CHECKSUM_FAIL || MEMORY_CHECK_FAIL || ref_fail_reg || force_err_reg)) |=> S_AXI_RDATA == 32'h0)
        else $error("quality word not suppressed");

    // Live status inputs reach the read word
    chk_status_inputs: assert property (@(posedge CLK) disable iff (!RST_N)
        (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR[7:2] == 6'h0d) |=> S_AXI_RDATA[13:10]
        == $past({MEMORY_CHECK_FAIL, ref_fail_reg, CALIB_MEMORY_PROGRAM_ENABLE, LINE_TRACK_PRESENT}))
        else $error("status inputs not reported");

    // Reference failure is unrecoverable; only a reset
    // starts a fresh check
    chk_ref_sticky: assert property (@(posedge CLK) disable iff (!RST_N)
        ref_fail_reg |=> ref_fail_reg)
        else $error("reference failure cleared");
endmodule : aics_regs

// ### tb/aics_front_model.sv
// Front-end model: point data per word and the reference pulse train
`timescale 1ns/1ps
module aics_front_model #(
    parameter int unsigned PERIOD = 200
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ref_on,
    input  wire logic [3:0]  point_index,
    output logic      [15:0] point_data,
    output logic             ref_pulse
);
    // ==========================================
    // Pulse spacing counter
    int cnt_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 0;
        end else begin
            cnt_reg <= (cnt_reg + 1) % PERIOD;
        end
    end
    // Generator off means no pulse at all, the fault case
    assign ref_pulse = ref_on && (cnt_reg == 0);
    // Distinct word per point so a wrong index shows up
    assign point_data = 16'ha5c0 | {12'h000, point_index};
endmodule : aics_front_model

// ### tb/tb_analog_input_config_status_register.sv
// Self-checking bench for the config/status word with a behavioural model
`timescale 1ns/1ps
module tb_analog_input_config_status_register;
    logic        clk, rst_n, awv, wv, bready, arv, rready, awrdy, wrdy, bvalid, arrdy, rvalid, ref_on, refp;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [15:0] pdata, qual;
    logic [3:0]  pidx, wstrb;
    logic [1:0]  bresp, rresp, r;
    logic        chkf, memf, tempf, intf, lp, pgm_en, pcmd, led, pen, tb50, trk, pacc;
    int          n_fail, num_checks, cyc, cfg_m, frc_m, l50_m, trk_m, refbad_m;
    // ==========================================
    // Clock, design and front-end model
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    aics_regs #(.REF_WINDOW(8)) i_aics_regs (.CLK(clk), .RST_N(rst_n),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awrdy), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
        .S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .POINT_DATA(pdata), .POINT_QUALITY(qual), .CHECKSUM_FAIL(chkf),
        .MEMORY_CHECK_FAIL(memf), .TEMP_SENSOR_FAIL(tempf), .INTERNAL_FAULT(intf),
        .REFERENCE_PULSE(refp), .LINE_TRACK_PRESENT(lp), .CALIB_MEMORY_PROGRAM_ENABLE(pgm_en),
        .PROGRAM_CMD(pcmd), .POINT_INDEX(pidx), .INTERNAL_ERROR_LED(led), .POINT_PROCESS_EN(pen),
        .TIMEBASE_50HZ(tb50), .TRACKING_IN_USE(trk), .PROGRAM_ACCEPT(pacc));
    aics_front_model #(.PERIOD(4)) i_aics_front_model (.clk(clk), .rst_n(rst_n), .ref_on(ref_on),
        .point_index(pidx), .point_data(pdata), .ref_pulse(refp));
    // ==========================================
    // Compare, verdict and hang guard
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            finish_test();
        end
    end
    // ==========================================
    // AXI4-Lite master; ready sampled at the falling edge, so the handshake edge is known
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
        logic ta, tw, tb;
        @(posedge clk);
        {awaddr, wdata, awv, wv, bready} <= {a, d, 3'b111};
        tb = 1'b0;
        while (!tb) begin
            @(negedge clk);
            {ta, tw, tb, rs} = {awv & awrdy, wv & wrdy, bvalid & bready, bresp};
            @(posedge clk);
            {awv, wv, bready} <= {awv & !ta, wv & !tw, bready & !tb};
        end
    endtask : axw
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
        logic ta, tr;
        @(posedge clk);
        {araddr, arv, rready} <= {a, 2'b11};
        tr = 1'b0;
        while (!tr) begin
            @(negedge clk);
            {ta, tr, d, rs} = {arv & arrdy, rvalid & rready, rdata, rresp};
            @(posedge clk);
            {arv, rready} <= {arv & !ta, rready & !tr};
        end
    endtask : axr
    // Config write; only bits 0, 1, 8 and 9 may land in the model
    task automatic cfgw(input logic [31:0] d);
        axw(8'h34, d, r);
        chk(r, aics_pkg::RESP_OKAY);
        if (wstrb[0]) begin
            {cfg_m, frc_m} = {32'(d[0]), 32'(d[1])};
        end
        if (wstrb[1]) begin
            {l50_m, trk_m} = {32'(d[8]), 32'(d[9])};
        end
    endtask : cfgw
    // ==========================================
    // Reads status, quality and one point word, and the side outputs, against the model
    task automatic check_all();
        logic [31:0] d;
        logic [15:0] s;
        logic        e;
        int          w;
        e = intf | frc_m[0] | chkf | refbad_m[0] | memf;
        s = {(|qual) | e, tempf | chkf, memf, refbad_m[0], pgm_en, lp, trk_m[0] & lp, l50_m[0], chkf, 5'h00, e, cfg_m[0]};
        axr(8'h34, d, r);
        chk(d, {16'h0000, s});
        axr(8'h30, d, r);
        chk(d, (chkf | refbad_m[0] | memf | frc_m[0]) ? 32'h0 : {16'h0000, qual});
        w = $urandom_range(11);
        axr(8'(w * 4), d, r);
        chk(r, (e | !cfg_m[0]) ? aics_pkg::RESP_SLVERR : aics_pkg::RESP_OKAY);
        chk(d, (e | !cfg_m[0]) ? 32'h0 : 32'h0000a5c0 | 32'(w));
        chk({led, pen, tb50, trk}, {e, cfg_m[0] & !chkf, l50_m[0], trk_m[0] & lp});
    endtask : check_all
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        {cfg_m, frc_m, l50_m, trk_m, refbad_m} = {128'h0, 32'(!ref_on)};
        repeat (20) @(posedge clk);
    endtask : do_reset
    // ==========================================
    // Main sequence
    initial begin
        {rst_n, awv, wv, bready, arv, rready, chkf, memf, tempf, intf, lp, pgm_en, pcmd} = '0;
        wstrb = 4'hf;
        {awaddr, araddr, wdata, qual, ref_on, n_fail, num_checks, cyc} = {8'h00, 8'h00, 32'h0, 16'h0, 1'b1, 96'h0};
        void'($urandom(32'hc8a8));
        do_reset();
        check_all();
        axr(8'h38, rd, r);
        chk(r, aics_pkg::RESP_DECERR);
        axw(8'h3c, 32'h1, r);
        chk(r, aics_pkg::RESP_DECERR);
        axw(8'h00, 32'h1, r);
        chk(r, aics_pkg::RESP_SLVERR);
        check_all();
        $display("test reset and decode done");
        lp <= 1'b1;
        cfgw(32'h0000fffd);
        check_all();
        cfgw(32'h00000003);
        check_all();
        $display("test configure and force done");
        for (int i = 0; i < 12; i++) begin
            @(posedge clk);
            {chkf, memf, tempf, intf, lp, pgm_en} <= 6'($urandom) & 6'($urandom);
            wstrb <= 4'($urandom);
            qual <= ($urandom_range(2) == 0) ? 16'(1 << $urandom_range(15)) : 16'h0000;
            cfgw($urandom & 32'h0000ffff);
            check_all();
            pcmd <= 1'b1;
            @(posedge clk);
            pcmd <= 1'b0;
            @(negedge clk);
            chk(pacc, pgm_en);
        end
        $display("test random faults done");
        @(posedge clk) {ref_on, wstrb} <= {1'b0, 4'hf};
        do_reset();
        cfgw(32'h00000001);
        check_all();
        $display("test missing reference done");
        finish_test();
    end
endmodule : tb_analog_input_config_status_register
